//--- verilog/rfic_map.svh
// register map, field positions, codes and timing constants
`ifndef RFIC_MAP_SVH
`define RFIC_MAP_SVH
`define RFIC_OFF_CTRL0 8'h00
`define RFIC_OFF_CTRL4 8'h04
`define RFIC_OFF_CTRL5 8'h08
`define RFIC_OFF_CTRL6 8'h0C
`define RFIC_OFF_STATUS 8'h10
`define RFIC_OFF_IRQ_STS 8'h14
`define RFIC_OFF_IRQ_CLR 8'h18
`define RFIC_OFF_IRQ_EN 8'h1C
`define RFIC_OFF_TONE 8'h20
`define RFIC_OFF_FILT_RB 8'h24
`define RFIC_MUX_SEL_HI 31
`define RFIC_MUX_SEL_LO 29
`define RFIC_BW_HI 31
`define RFIC_BW_LO 30
`define RFIC_COARSE_BIT 4
`define RFIC_FINE_EN_BIT 4
`define RFIC_TRIM_HI 19
`define RFIC_TRIM_LO 14
`define RFIC_IQ_HI 31
`define RFIC_IQ_LO 20
`define RFIC_TONE_K_HI 6
`define RFIC_TONE_K_LO 0
`define RFIC_IR_MODE_BIT 8
`define RFIC_MUX_LOW 3'h0
`define RFIC_MUX_HIGH 3'h1
`define RFIC_MUX_CAL_DONE 3'h5
`define RFIC_MUX_IRQ 3'h6
`define RFIC_IRQ_COARSE 0
`define RFIC_IRQ_FINE 1
`define RFIC_IRQ_ACCESS 2
`define RFIC_IRQ_W 3
`define RFIC_RESP_OKAY 2'h0
`define RFIC_RESP_SLVERR 2'h2
`define RFIC_WORD_ZERO 32'h0000_0000
`define RFIC_IMAGE_OFFSET_KHZ 8'hC8
`define RFIC_CLK_PERIOD_PS 8000
`define RFIC_COARSE_TIME_US 200
`define RFIC_FINE_TIME_US 8200
`define RFIC_COARSE_CYCLES ((`RFIC_COARSE_TIME_US * 1000) / (`RFIC_CLK_PERIOD_PS / 1000))
`define RFIC_FINE_CYCLES ((`RFIC_FINE_TIME_US * 1000) / (`RFIC_CLK_PERIOD_PS / 1000))
`define RFIC_CNT_W 21
`endif

//--- verilog/rfic_pkg.sv
// types shared by the calibration block
package rfic_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_COARSE, ST_FINE} rfic_state_type;
  typedef logic [31:0] rfic_word_type;
  typedef logic [7:0] rfic_addr_type;
endpackage

//--- verilog/rfic_cal_if.sv
// control and status bundle between register file and sequencer
`timescale 1ns/1ps
interface rfic_cal_if;
  logic start;
  logic fine_en;
  logic busy;
  logic done;
  logic coarse_end;
  logic fine_end;
  modport ctrl (output start, output fine_en, input busy, input done, input coarse_end,
    input fine_end);
  modport seq (input start, input fine_en, output busy, output done, output coarse_end,
    output fine_end);
endinterface

//--- verilog/rfic_sync.sv
// two-flop synchroniser for a bus of slow levels
`timescale 1ns/1ps
module rfic_sync #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= '0;
      dout <= '0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // rfic_sync

//--- verilog/rfic_cal_seq.sv
// coarse then optional fine filter calibration sequencer
`timescale 1ns/1ps
`include "rfic_map.svh"
module rfic_cal_seq #(
  parameter int COARSE_CYCLES = `RFIC_COARSE_CYCLES,
  parameter int FINE_CYCLES = `RFIC_FINE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  rfic_cal_if.seq cal
);
  import rfic_pkg::*;
  rfic_state_type state, next_state;
  logic [`RFIC_CNT_W-1:0] cnt;
  logic [`RFIC_CNT_W-1:0] next_cnt;
  logic fine_lat;
  logic done;
  logic coarse_last;
  logic fine_last;
  logic next_done;

  // end-of-phase decode
  assign coarse_last = (state == ST_COARSE) && (cnt == `RFIC_CNT_W'(COARSE_CYCLES - 1));
  assign fine_last = (state == ST_FINE) && (cnt == `RFIC_CNT_W'(FINE_CYCLES - 1));
  assign cal.busy = (state != ST_IDLE);
  assign cal.done = done;
  assign cal.coarse_end = coarse_last;
  assign cal.fine_end = fine_last;
  assign next_done = (cal.start && state == ST_IDLE) ? 1'b0 :
    (coarse_last && !fine_lat) || fine_last ? 1'b1 : done;

  // phase sequencing, fine always preceded by coarse
  always_comb
  begin
    next_state = state;
    next_cnt = cnt + `RFIC_CNT_W'(1);
    unique case (state)
      ST_IDLE:
      begin
        next_cnt = '0;
        if (cal.start)
          next_state = ST_COARSE;
      end
      ST_COARSE:
      begin
        if (coarse_last)
        begin
          next_cnt = '0;
          next_state = fine_lat ? ST_FINE : ST_IDLE;
        end
      end
      ST_FINE:
      begin
        if (fine_last)
        begin
          next_cnt = '0;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // state, counter, done flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      done <= 1'b0;
      fine_lat <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      done <= next_done;
      if (state == ST_IDLE && cal.start)
        fine_lat <= cal.fine_en;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_coarse_hold: assert property ((state == ST_COARSE && !coarse_last) |=> state == ST_COARSE)
    else $error("coarse phase ended early");
  a_coarse_len: assert property ($rose(state == ST_COARSE) |-> cnt == '0)
    else $error("coarse counter not cleared at start");
  a_fine_follow: assert property ((coarse_last && fine_lat) |=> state == ST_FINE)
    else $error("fine phase did not follow coarse");
  a_done_low: assert property (cal.busy |=> (!done || !cal.busy))
    else $error("done shown while calibration runs");
  c_coarse_only: cover property (coarse_last && !fine_lat);
  c_fine_end: cover property (fine_last);
endmodule // rfic_cal_seq

//--- verilog/rfic_top.sv
// filter and image calibration control with axi4-lite register access
`timescale 1ns/1ps
`include "rfic_map.svh"
module rfic_top #(
  parameter int COARSE_CYCLES = `RFIC_COARSE_CYCLES,
  parameter int FINE_CYCLES = `RFIC_FINE_CYCLES,
  parameter int CODE_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire rfic_pkg::rfic_addr_type awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire rfic_pkg::rfic_word_type wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire rfic_pkg::rfic_addr_type araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output rfic_pkg::rfic_word_type rdata,
  output logic [1:0] rresp,
  input wire logic [CODE_W-1:0] filter_tune_code,
  output logic multiplexed_status_output,
  output logic [1:0] filter_bandwidth_select,
  output logic [5:0] filter_trim,
  output logic [11:0] iq_correction,
  output logic cal_coarse_run,
  output logic cal_fine_run,
  output logic [7:0] test_tone_multiple,
  output logic [7:0] lo_offset_khz,
  output logic irq
);
  import rfic_pkg::*;
  rfic_cal_if cal ();
  rfic_word_type ctrl0, ctrl4, ctrl5, ctrl6, tone;
  rfic_addr_type aw_addr_q;
  rfic_word_type w_data_q, wmask, rd_word;
  logic [3:0] w_strb_q;
  logic aw_full, w_full, next_aw_full, next_w_full, do_write, do_read;
  logic wr_ok, rd_ok, wr_ctrl5, start_req, start_q;
  logic [`RFIC_IRQ_W-1:0] irq_sts, irq_en, irq_clr, irq_evt, next_irq_sts;
  logic [CODE_W-1:0] code_sync, fine_result;
  logic next_mux;
  logic fine_armed;
  logic [2:0] mux_sel;
  logic [11:0] iq_field;

  rfic_sync #(.WIDTH(CODE_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(filter_tune_code),
    .dout(code_sync)
  );

  rfic_cal_seq #(.COARSE_CYCLES(COARSE_CYCLES), .FINE_CYCLES(FINE_CYCLES)) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .cal(cal.seq)
  );

  // write channel capture; address and data may arrive in either order
  assign do_write = aw_full && w_full && !bvalid;
  assign next_aw_full = (aw_full || (awvalid && awready)) && !do_write;
  assign next_w_full = (w_full || (wvalid && wready)) && !do_write;
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_ok = (aw_addr_q == `RFIC_OFF_CTRL0) || (aw_addr_q == `RFIC_OFF_CTRL4) ||
    (aw_addr_q == `RFIC_OFF_CTRL5) || (aw_addr_q == `RFIC_OFF_CTRL6) ||
    (aw_addr_q == `RFIC_OFF_IRQ_CLR) || (aw_addr_q == `RFIC_OFF_IRQ_EN) ||
    (aw_addr_q == `RFIC_OFF_TONE);
  assign wr_ctrl5 = do_write && (aw_addr_q == `RFIC_OFF_CTRL5);
  assign start_req = wr_ctrl5 && w_strb_q[0] && w_data_q[`RFIC_COARSE_BIT] && !cal.busy;
  assign irq_clr = (do_write && aw_addr_q == `RFIC_OFF_IRQ_CLR && w_strb_q[0]) ?
    w_data_q[`RFIC_IRQ_W-1:0] : '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RFIC_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= `RFIC_WORD_ZERO;
      w_strb_q <= '0;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awready <= !next_aw_full;
      wready <= !next_w_full;
      if (awvalid && awready)
        aw_addr_q <= awaddr;
      if (wvalid && wready)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RFIC_RESP_OKAY : `RFIC_RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // control registers with byte lanes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl0 <= `RFIC_WORD_ZERO;
      ctrl4 <= `RFIC_WORD_ZERO;
      ctrl5 <= `RFIC_WORD_ZERO;
      ctrl6 <= `RFIC_WORD_ZERO;
      tone <= `RFIC_WORD_ZERO;
      irq_en <= '0;
    end
    else if (do_write)
    begin
      if (aw_addr_q == `RFIC_OFF_CTRL0)
        ctrl0 <= (ctrl0 & ~wmask) | (w_data_q & wmask);
      if (aw_addr_q == `RFIC_OFF_CTRL4)
        ctrl4 <= (ctrl4 & ~wmask) | (w_data_q & wmask);
      if (aw_addr_q == `RFIC_OFF_CTRL5)
        ctrl5 <= (ctrl5 & ~wmask) | (w_data_q & wmask);
      if (aw_addr_q == `RFIC_OFF_CTRL6)
        ctrl6 <= (ctrl6 & ~wmask) | (w_data_q & wmask);
      if (aw_addr_q == `RFIC_OFF_TONE)
        tone <= (tone & ~wmask) | (w_data_q & wmask);
      if (aw_addr_q == `RFIC_OFF_IRQ_EN && w_strb_q[0])
        irq_en <= w_data_q[`RFIC_IRQ_W-1:0];
    end
  end

  // read channel: one read at a time, data from a register
  assign do_read = arvalid && arready;
  assign rd_ok = (araddr == `RFIC_OFF_CTRL0) || (araddr == `RFIC_OFF_CTRL4) ||
    (araddr == `RFIC_OFF_CTRL5) || (araddr == `RFIC_OFF_CTRL6) ||
    (araddr == `RFIC_OFF_STATUS) || (araddr == `RFIC_OFF_IRQ_STS) ||
    (araddr == `RFIC_OFF_IRQ_CLR) || (araddr == `RFIC_OFF_IRQ_EN) ||
    (araddr == `RFIC_OFF_TONE) || (araddr == `RFIC_OFF_FILT_RB);
  assign rd_word =
    (araddr == `RFIC_OFF_CTRL0) ? ctrl0 :
    (araddr == `RFIC_OFF_CTRL4) ? ctrl4 :
    (araddr == `RFIC_OFF_CTRL5) ? ctrl5 :
    (araddr == `RFIC_OFF_CTRL6) ? ctrl6 :
    (araddr == `RFIC_OFF_STATUS) ? {29'h0000_0000, cal_fine_run, cal.done, cal.busy} :
    (araddr == `RFIC_OFF_IRQ_STS) ? {29'h0000_0000, irq_sts} :
    (araddr == `RFIC_OFF_IRQ_EN) ? {29'h0000_0000, irq_en} :
    (araddr == `RFIC_OFF_TONE) ? tone :
    (araddr == `RFIC_OFF_FILT_RB) ? rfic_word_type'(fine_result) :
    `RFIC_WORD_ZERO;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= `RFIC_WORD_ZERO;
      rresp <= `RFIC_RESP_OKAY;
    end
    else if (do_read)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_ok ? `RFIC_RESP_OKAY : `RFIC_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end

  // sticky events, set wins over clear
  assign irq_evt = {do_write && cal.busy, cal.fine_end, cal.coarse_end};
  assign next_irq_sts = (irq_sts & ~irq_clr) | irq_evt;
  assign cal.start = start_q;
  assign cal.fine_en = ctrl6[`RFIC_FINE_EN_BIT];
  assign mux_sel = ctrl0[`RFIC_MUX_SEL_HI:`RFIC_MUX_SEL_LO];
  assign iq_field = ctrl5[`RFIC_IQ_HI:`RFIC_IQ_LO];
  assign next_mux = (mux_sel == `RFIC_MUX_HIGH) ? 1'b1 :
    (mux_sel == `RFIC_MUX_CAL_DONE) ? cal.done :
    (mux_sel == `RFIC_MUX_IRQ) ? irq : 1'b0;

  // interrupt, readback and phase flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_q <= 1'b0;
      irq_sts <= '0;
      irq <= 1'b0;
      fine_result <= '0;
      fine_armed <= 1'b0;
      cal_coarse_run <= 1'b0;
      cal_fine_run <= 1'b0;
    end
    else
    begin
      start_q <= start_req;
      irq_sts <= next_irq_sts;
      irq <= |(next_irq_sts & irq_en);
      if (cal.fine_end)
        fine_result <= code_sync;
      if (cal.start)
        fine_armed <= cal.fine_en; // same choice the sequencer latches
      cal_coarse_run <= cal.busy && !cal_fine_run && !cal.coarse_end;
      cal_fine_run <= (cal_fine_run && !cal.fine_end) || (cal.coarse_end && fine_armed);
    end
  end

  // register-driven pins, each from its own flop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      multiplexed_status_output <= 1'b0;
      filter_bandwidth_select <= '0;
      filter_trim <= '0;
      iq_correction <= '0;
      test_tone_multiple <= 8'h01;
      lo_offset_khz <= 8'h00;
    end
    else
    begin
      multiplexed_status_output <= next_mux;
      filter_bandwidth_select <= ctrl4[`RFIC_BW_HI:`RFIC_BW_LO];
      filter_trim <= ctrl5[`RFIC_TRIM_HI:`RFIC_TRIM_LO];
      iq_correction <= iq_field;
      test_tone_multiple <= {tone[`RFIC_TONE_K_HI:`RFIC_TONE_K_LO], 1'b1};
      lo_offset_khz <= tone[`RFIC_IR_MODE_BIT] ? `RFIC_IMAGE_OFFSET_KHZ : 8'h00;
    end
  end

  // sequence, register and bus checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_mux_done: assert property ((mux_sel == `RFIC_MUX_CAL_DONE) |=>
    multiplexed_status_output == $past(cal.done))
    else $error("status pin does not follow done");
  a_start_run: assert property (start_req |-> ##2 cal.busy)
    else $error("coarse write did not start calibration");
  a_start_done: assert property (start_req |-> ##3 !cal.done)
    else $error("done not cleared at start");
  a_readback: assert property (cal.fine_end |=> fine_result == $past(code_sync))
    else $error("fine result not captured");
  a_iq_apply: assert property (##1 iq_correction == $past(iq_field))
    else $error("iq trims not applied");
  a_tone_odd: assert property (test_tone_multiple[0])
    else $error("test tone multiple is even");
  a_image_off: assert property (tone[`RFIC_IR_MODE_BIT] |=>
    lo_offset_khz == `RFIC_IMAGE_OFFSET_KHZ)
    else $error("image offset not 200 kHz");
  a_resp_hold: assert property ((bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property ((rvalid && !rready) |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_bresp_err: assert property ((do_write && !wr_ok) |=> bresp == `RFIC_RESP_SLVERR)
    else $error("unmapped write not refused");
  a_sts_sticky: assert property ((irq_sts[`RFIC_IRQ_COARSE] && !irq_clr[`RFIC_IRQ_COARSE]) |=>
    irq_sts[`RFIC_IRQ_COARSE])
    else $error("status bit lost without clear");
  a_access_flag: assert property ((do_write && cal.busy) |=> irq_sts[`RFIC_IRQ_ACCESS])
    else $error("access during run not flagged");
  a_fine_in_run: assert property (cal_fine_run |-> cal.busy)
    else $error("fine phase shown while idle");
  a_coarse_in_run: assert property (cal_coarse_run |-> cal.busy)
    else $error("coarse phase shown while idle");
  // main scenarios
  c_start: cover property (start_req);
  c_fine_seq: cover property (cal.coarse_end && cal.fine_en);
  c_unmapped: cover property (rvalid && rresp == `RFIC_RESP_SLVERR);
endmodule // rfic_top

//--- dv/rfic_host_model.sv
// host bus master model driving the register port
`timescale 1ns/1ps
module rfic_host_model (
  input wire logic aclk,
  output logic awvalid,
  input wire logic awready,
  output rfic_pkg::rfic_addr_type awaddr,
  output logic [2:0] awprot,
  output logic wvalid,
  input wire logic wready,
  output rfic_pkg::rfic_word_type wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output rfic_pkg::rfic_addr_type araddr,
  output logic [2:0] arprot,
  input wire logic rvalid,
  output logic rready,
  input wire rfic_pkg::rfic_word_type rdata,
  input wire logic [1:0] rresp
);
  import rfic_pkg::*;
  // idle bus from time zero
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awprot, arprot} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
  end
  // one write, payload inverted once released
  task automatic write(input rfic_addr_type a, input rfic_word_type d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  // one read, data taken at the rvalid edge
  task automatic read(input rfic_addr_type a, output rfic_word_type d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // rfic_host_model

//--- dv/test_receiver_filter_and_image_calibration.sv
// self-checking bench for the calibration block
`timescale 1ns/1ps
`include "rfic_map.svh"
module test_receiver_filter_and_image_calibration;
  import rfic_pkg::*;
  localparam int COARSE = 20;
  localparam int FINE = 40;
  localparam rfic_word_type ONE = 32'h0000_0001;
  localparam rfic_word_type NIL = 32'h0000_0000;
  typedef struct {rfic_addr_type a; rfic_word_type d;} rfic_row_type;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, mux_out, coarse_run, fine_run, irq;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, bw_sel;
  rfic_addr_type awaddr, araddr;
  rfic_word_type wdata, rdata;
  logic [7:0] tune_code, tone, lo_off;
  logic [5:0] trim;
  logic [11:0] iq;
  int err_total, cmp_count;
  rfic_row_type rows [5];
  rfic_top #(.COARSE_CYCLES(COARSE), .FINE_CYCLES(FINE), .CODE_W(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .filter_tune_code(tune_code), .multiplexed_status_output(mux_out),
    .filter_bandwidth_select(bw_sel), .filter_trim(trim), .iq_correction(iq),
    .cal_coarse_run(coarse_run), .cal_fine_run(fine_run), .test_tone_multiple(tone),
    .lo_offset_khz(lo_off), .irq(irq));
  rfic_host_model u_host (
    .aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  // clock and time-zero inputs
  initial
  begin
    aclk = 1'b0;
    aresetn = 1'b0;
    tune_code = 8'hA5;
    err_total = 0;
    cmp_count = 0;
  end
  always #4 aclk = ~aclk;
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input rfic_word_type seen, input rfic_word_type exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(negedge aclk);
  endtask
  task automatic wr(input rfic_addr_type a, input rfic_word_type d, input logic [1:0] e);
    logic [1:0] r;
    u_host.write(a, d, r);
    check("bresp", 32'(r), 32'(e));
  endtask
  task automatic rd(input rfic_addr_type a, input rfic_word_type e, input logic [1:0] er);
    rfic_word_type v;
    logic [1:0] r;
    u_host.read(a, v, r);
    check("rdata", v, e);
    check("rresp", 32'(r), 32'(er));
  endtask
  // start a run, follow its phases, host stays off the bus until done
  task automatic cal(input logic fine);
    int m;
    int lim;
    wr(`RFIC_OFF_CTRL6, {27'h000_0000, fine, 4'h0}, 2'h0);
    wr(`RFIC_OFF_CTRL0, 32'hA000_0000, 2'h0);
    wr(`RFIC_OFF_CTRL5, 32'h0000_0010, 2'h0);
    settle(3);
    check("coarse", 32'(coarse_run), ONE);
    check("fine", 32'(fine_run), NIL);
    check("done", 32'(mux_out), NIL);
    m = 3;
    if (fine)
    begin
      settle(COARSE);
      m = m + COARSE;
      check("coarse", 32'(coarse_run), NIL);
      check("fine", 32'(fine_run), ONE);
    end
    lim = fine ? COARSE + FINE : COARSE;
    while (mux_out !== 1'b1 && m < 2000)
    begin
      @(negedge aclk);
      m++;
    end
    check("cal time", 32'(m >= lim - 2 && m <= lim + 8), ONE);
  endtask
  // hang guard
  initial
  begin
    repeat (10000) @(posedge aclk);
    err_total++;
    end_sim();
  end
  initial
  begin
    rows = '{'{`RFIC_OFF_CTRL4, 32'hC000_0000}, '{`RFIC_OFF_CTRL5, 32'hFFFF_C000},
      '{`RFIC_OFF_CTRL6, NIL}, '{`RFIC_OFF_CTRL0, 32'hA000_0000},
      '{`RFIC_OFF_IRQ_EN, 32'h0000_0007}};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    check("tone", 32'(tone), ONE);
    check("mux", 32'(mux_out), NIL);
    rd(`RFIC_OFF_STATUS, NIL, 2'h0);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d, 2'h0);
      rd(rows[i].a, rows[i].d, 2'h0);
    end
    settle(1);
    check("bw", 32'(bw_sel), 32'h0000_0003);
    check("trim", 32'(trim), 32'h0000_003F);
    check("iq", 32'(iq), 32'h0000_0FFF);
    wr(8'h40, 32'hFFFF_FFFF, `RFIC_RESP_SLVERR);
    rd(8'h40, NIL, `RFIC_RESP_SLVERR);
    wr(`RFIC_OFF_TONE, 32'h0000_0105, 2'h0);
    settle(1);
    check("tone", 32'(tone), 32'h0000_000B);
    check("lo", 32'(lo_off), 32'h0000_00C8);
    wr(`RFIC_OFF_TONE, 32'h0000_007F, 2'h0);
    settle(1);
    check("tone", 32'(tone), 32'h0000_00FF);
    check("lo", 32'(lo_off), NIL);
    cal(1'b0);
    settle(2);
    check("irq", 32'(irq), ONE);
    rd(`RFIC_OFF_IRQ_STS, ONE, 2'h0);
    // other status pin codes: irq, high, low
    for (int i = 0; i < 3; i++)
    begin
      wr(`RFIC_OFF_CTRL0, {(i == 0) ? `RFIC_MUX_IRQ : (i == 1) ? `RFIC_MUX_HIGH :
        `RFIC_MUX_LOW, 29'h0000_0000}, 2'h0);
      settle(2);
      check("mux", 32'(mux_out), 32'(i < 2));
    end
    wr(`RFIC_OFF_IRQ_CLR, ONE, 2'h0);
    settle(2);
    check("irq", 32'(irq), NIL);
    rd(`RFIC_OFF_IRQ_STS, NIL, 2'h0);
    rd(`RFIC_OFF_IRQ_CLR, NIL, 2'h0);
    cal(1'b1);
    rd(`RFIC_OFF_FILT_RB, 32'h0000_00A5, 2'h0);
    rd(`RFIC_OFF_IRQ_STS, 32'h0000_0003, 2'h0);
    wr(`RFIC_OFF_IRQ_EN, NIL, 2'h0);
    settle(2);
    check("irq masked", 32'(irq), NIL);
    wr(`RFIC_OFF_IRQ_CLR, 32'h0000_0007, 2'h0);
    wr(`RFIC_OFF_IRQ_EN, 32'h0000_0007, 2'h0);
    // image trim sweep, internal tone then external tone
    for (int j = 0; j < 2; j++)
    begin
      wr(`RFIC_OFF_TONE, (j == 0) ? 32'h0000_0105 : NIL, 2'h0);
      for (int i = 0; i < 3; i++)
      begin
        wr(`RFIC_OFF_CTRL5, {12'(i * 12'h555), 20'h0_0000}, 2'h0);
        settle(1);
        check("iq sweep", 32'(iq), 32'(i * 12'h555));
        check("lo", 32'(lo_off), (j == 0) ? 32'h0000_00C8 : NIL);
      end
    end
    // stored fine result put back by hand
    wr(`RFIC_OFF_CTRL5, 32'h0009_4000, 2'h0);
    settle(1);
    check("trim", 32'(trim), 32'h0000_0025);
    // access during a run on purpose: flagged
    wr(`RFIC_OFF_CTRL6, NIL, 2'h0);
    wr(`RFIC_OFF_CTRL5, 32'h0000_0010, 2'h0);
    wr(`RFIC_OFF_CTRL4, NIL, 2'h0);
    settle(COARSE + 8);
    rd(`RFIC_OFF_IRQ_STS, 32'h0000_0005, 2'h0);
    check("irq", 32'(irq), ONE);
    // second reset in the middle of a fine phase
    wr(`RFIC_OFF_CTRL6, 32'h0000_0010, 2'h0);
    wr(`RFIC_OFF_CTRL5, 32'h0000_0010, 2'h0);
    settle(COARSE + 3);
    rd(`RFIC_OFF_STATUS, 32'h0000_0005, 2'h0);
    check("fine", 32'(fine_run), ONE);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(1);
    check("tone", 32'(tone), ONE);
    check("trim", 32'(trim), NIL);
    check("irq", 32'(irq), NIL);
    check("coarse", 32'(coarse_run), NIL);
    check("fine", 32'(fine_run), NIL);
    rd(`RFIC_OFF_STATUS, NIL, 2'h0);
    end_sim();
  end
endmodule // test_receiver_filter_and_image_calibration
